// ---- rtl/bit_test_skip_exec.sv ----
// module: execution of the two bit-test-and-skip instructions, one per instruction cycle
`timescale 1ns/1ps
// How it works
// - skip-when-set skips the next instruction when the tested bit is 1.
// - a taken skip discards the prefetched word and runs a no-operation.
// - a taken skip makes the test take two instruction cycles.
// - access bit 0 addresses the access bank, ignoring the bank selector, except in the indexed case below.
// - access bit 1 uses the bank selector to pick the register bank.
// - access 0 with extended set and address up to 95 uses indexed offset.
module bit_test_skip_exec
  import bit_skip_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // instruction stream, one word per instruction cycle
  input fetch_t fetch,
  input wire logic [3:0] bank_selector,
  input wire logic ext_set_en,
  input wire logic [11:0] index_base,
  // data memory read
  input wire logic [7:0] file_rdata,
  output logic [11:0] file_addr_reg,
  output logic file_rd_reg,
  output addr_mode_t addr_mode_reg,
  // results
  output logic [1:0] phase_reg,
  output logic skip_reg,
  output logic nop_reg,
  output logic busy_reg
);
  // ----------------------------------------
  // phase and state
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_TEST = 3'b010,
    ST_FLUSH = 3'b100
  } state_t;

  state_t state_reg;
  logic is_test;
  logic want_set_reg;
  logic [2:0] bit_sel_reg;
  logic bit_val;
  logic take;
  file_req_t req;

  function automatic logic is_bit_test(input logic [15:0] w);
    is_bit_test = (w[OPC_MSB:OPC_LSB] == OPC_SKIP_WHEN_SET) ||
                  (w[OPC_MSB:OPC_LSB] == OPC_SKIP_WHEN_CLEAR);
  endfunction

  file_addr_resolve u_resolve (
    .file_addr(fetch.word[7:0]),
    .access_sel(fetch.word[ACC_POS]),
    .bank_selector(bank_selector),
    .ext_set_en(ext_set_en),
    .index_base(index_base),
    .req(req)
  );

  assign is_test = fetch.valid && is_bit_test(fetch.word);
  assign bit_val = file_rdata[bit_sel_reg];
  // want_set picks polarity: set form tests for 1, clear form for 0
  assign take = (bit_val == want_set_reg);

  // four q phases make one instruction cycle; decisions land on the last
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase_reg <= PHASE_RESET;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
    end else if (phase_reg == PHASE_LAST) begin
      unique case (state_reg)
        ST_IDLE: begin
          if (is_test) begin
            state_reg <= ST_TEST;
          end
        end
        ST_TEST: begin
          // taken skip adds a cycle for the forced no-operation
          state_reg <= take ? ST_FLUSH : (is_test ? ST_TEST : ST_IDLE);
        end
        ST_FLUSH: begin
          // the swallowed word went by in the decision cycle; the word fetched
          // during the nop is a real instruction and must be decoded
          state_reg <= is_test ? ST_TEST : ST_IDLE;
        end
      endcase
    end
  end

  // operand capture at the end of the decode cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      want_set_reg <= 1'b0;
      bit_sel_reg <= 3'h0;
      file_addr_reg <= 12'h000;
      addr_mode_reg <= ADDR_BANKED;
      file_rd_reg <= 1'b0;
    end else if (phase_reg == PHASE_LAST) begin
      file_rd_reg <= 1'b0;
      // only the word that arrives with a taken skip is dropped, never the next one
      if (is_test && !(state_reg == ST_TEST && take)) begin
        want_set_reg <= (fetch.word[OPC_MSB:OPC_LSB] == OPC_SKIP_WHEN_SET);
        bit_sel_reg <= fetch.word[BIT_MSB:BIT_LSB];
        file_addr_reg <= req.addr;
        addr_mode_reg <= req.mode;
        file_rd_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // results
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      skip_reg <= 1'b0;
      nop_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else if (phase_reg == PHASE_LAST) begin
      skip_reg <= (state_reg == ST_TEST) && take;
      nop_reg <= (state_reg == ST_TEST) && take;
      busy_reg <= (state_reg == ST_TEST) && take;
    end
  end

  // ----------------------------------------
  // checks: skip decision
  // ----------------------------------------
  a_set_skips: assert property (@(posedge clk_sys) disable iff (rst)
    (phase_reg == PHASE_LAST && state_reg == ST_TEST && want_set_reg && bit_val)
    |=> skip_reg) else $error("set bit did not skip");
  a_clear_skips: assert property (@(posedge clk_sys) disable iff (rst)
    (phase_reg == PHASE_LAST && state_reg == ST_TEST && !want_set_reg && !bit_val)
    |=> skip_reg) else $error("clear bit did not skip");
  a_no_false_skip: assert property (@(posedge clk_sys) disable iff (rst)
    (phase_reg == PHASE_LAST && state_reg == ST_TEST && bit_val != want_set_reg)
    |=> !skip_reg) else $error("skip without matching bit");
  a_skip_after_read: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(skip_reg) |-> $past(file_rd_reg)) else $error("skip without a file read");
  a_rd_follows_test: assert property (@(posedge clk_sys) disable iff (rst)
    (phase_reg == PHASE_LAST && is_test && state_reg == ST_IDLE)
    |=> file_rd_reg) else $error("test word not read");
  a_no_rd_idle: assert property (@(posedge clk_sys) disable iff (rst)
    (phase_reg == PHASE_LAST && !is_test)
    |=> !file_rd_reg) else $error("read without a test word");

  // ----------------------------------------
  // checks: discard and forced no-operation
  // ----------------------------------------
  // a skip swallows exactly one word; the word arriving during the nop is decoded
  a_skip_nop: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(skip_reg) |-> nop_reg && state_reg == ST_FLUSH) else $error("skip without nop");
  a_nop_is_skip: assert property (@(posedge clk_sys) disable iff (rst)
    nop_reg == skip_reg) else $error("nop and skip disagree");
  a_flush_no_rd: assert property (@(posedge clk_sys) disable iff (rst)
    (phase_reg == PHASE_LAST && state_reg == ST_TEST && take)
    |=> !file_rd_reg && $stable(file_addr_reg)) else $error("discarded word decoded");
  a_nop_no_read: assert property (@(posedge clk_sys) disable iff (rst)
    state_reg == ST_FLUSH |-> !file_rd_reg) else $error("read during nop");
  a_flush_decodes: assert property (@(posedge clk_sys) disable iff (rst)
    (phase_reg == PHASE_LAST && state_reg == ST_FLUSH && is_test)
    |=> file_rd_reg && state_reg == ST_TEST) else $error("word after nop lost");

  // ----------------------------------------
  // checks: instruction cycle timing
  // ----------------------------------------
  // every result stands for one whole instruction cycle of four phases
  a_flush_len: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(nop_reg) |-> nop_reg [*4] ##1 !nop_reg) else $error("nop not one cycle");
  a_busy_len: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(busy_reg) |-> busy_reg [*4] ##1 !busy_reg) else $error("busy not one cycle");
  a_skip_len: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(skip_reg) |-> skip_reg [*4] ##1 !skip_reg) else $error("skip not one cycle");
  a_rd_len: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(file_rd_reg) |-> file_rd_reg [*4]) else $error("read request cut short");
  a_phase_wrap: assert property (@(posedge clk_sys) disable iff (rst)
    phase_reg == PHASE_LAST |=> phase_reg == PHASE_RESET) else $error("phase count broken");
  a_skip_on_phase: assert property (@(posedge clk_sys) disable iff (rst)
    $changed(skip_reg) |-> $past(phase_reg) == PHASE_LAST) else $error("skip moved off phase");
  a_addr_stands: assert property (@(posedge clk_sys) disable iff (rst)
    phase_reg != PHASE_LAST |=> $stable(file_addr_reg) && $stable(addr_mode_reg))
    else $error("address changed inside a cycle");
  a_state_onehot: assert property (@(posedge clk_sys) disable iff (rst)
    $onehot(state_reg)) else $error("state code illegal");

  // ----------------------------------------
  // checks: file addressing
  // ----------------------------------------
  // operands are captured on the decode edge only, so results are checked a clock later
  a_access_bank: assert property (@(posedge clk_sys) disable iff (rst)
    (phase_reg == PHASE_LAST && is_test && state_reg == ST_IDLE && !fetch.word[ACC_POS]
     && !ext_set_en) |=> addr_mode_reg == ADDR_ACCESS) else $error("access bank not used");
  a_access_split: assert property (@(posedge clk_sys) disable iff (rst)
    addr_mode_reg == ADDR_ACCESS |-> file_addr_reg[11:8] ==
    ((file_addr_reg[7:0] < ACCESS_SPLIT) ? BANK_RESET : ACCESS_HIGH_BANK))
    else $error("access bank half wrong");
  a_banked_addr: assert property (@(posedge clk_sys) disable iff (rst)
    (phase_reg == PHASE_LAST && is_test && state_reg == ST_IDLE && fetch.word[ACC_POS])
    |=> file_addr_reg[11:8] == $past(bank_selector)) else $error("bank selector ignored");
  a_banked_mode: assert property (@(posedge clk_sys) disable iff (rst)
    (phase_reg == PHASE_LAST && is_test && state_reg == ST_IDLE && fetch.word[ACC_POS])
    |=> addr_mode_reg == ADDR_BANKED) else $error("banked mode missed");
  a_indexed: assert property (@(posedge clk_sys) disable iff (rst)
    (phase_reg == PHASE_LAST && is_test && state_reg == ST_IDLE && !fetch.word[ACC_POS]
     && ext_set_en && fetch.word[7:0] <= INDEXED_LIMIT)
    |=> addr_mode_reg == ADDR_INDEXED) else $error("indexed mode missed");

  // ----------------------------------------
  // coverage of the main scenarios
  // ----------------------------------------
  c_skip_set: cover property (@(posedge clk_sys) $rose(skip_reg) && want_set_reg);
  c_skip_clear: cover property (@(posedge clk_sys) $rose(skip_reg) && !want_set_reg);
  c_indexed: cover property (@(posedge clk_sys) addr_mode_reg == ADDR_INDEXED && file_rd_reg);
  c_no_skip: cover property (@(posedge clk_sys) state_reg == ST_TEST && !take);
  c_word_after_nop: cover property (@(posedge clk_sys)
    phase_reg == PHASE_LAST && state_reg == ST_FLUSH && is_test);
endmodule

// ---- rtl/file_addr_resolve.sv ----
// module: resolves a file operand into a full data address and mode
`timescale 1ns/1ps
module file_addr_resolve
  import bit_skip_pkg::*;
(
  // operand
  input wire logic [7:0] file_addr,
  input wire logic access_sel,
  // core state
  input wire logic [3:0] bank_selector,
  input wire logic ext_set_en,
  input wire logic [11:0] index_base,
  // result
  output file_req_t req
);
  always_comb begin
    if (!access_sel && ext_set_en && file_addr <= INDEXED_LIMIT) begin
      // indexed literal offset: base pointer plus literal
      req.addr = 12'(index_base + {4'h0, file_addr});
      req.mode = ADDR_INDEXED;
    end else if (!access_sel) begin
      // the low 96 addresses map to bank 0, the other 160 to the special register bank
      req.addr = (file_addr < ACCESS_SPLIT) ? {BANK_RESET, file_addr}
                                            : {ACCESS_HIGH_BANK, file_addr};
      req.mode = ADDR_ACCESS;
    end else begin
      req.addr = {bank_selector, file_addr};
      req.mode = ADDR_BANKED;
    end
  end
endmodule

// ---- shared/bit_skip_pkg.sv ----
// package: opcodes, addressing constants and carriers for the bit-test-skip execution block
package bit_skip_pkg;
  localparam logic [3:0] OPC_SKIP_WHEN_CLEAR = 4'hB;
  localparam logic [3:0] OPC_SKIP_WHEN_SET = 4'hA;
  localparam int OPC_MSB = 15;
  localparam int OPC_LSB = 12;
  localparam int BIT_MSB = 11;
  localparam int BIT_LSB = 9;
  localparam int ACC_POS = 8;
  localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [3:0] BANK_RESET = 4'h0;
  localparam logic [1:0] PHASE_RESET = 2'h0;
  localparam logic [1:0] PHASE_LAST = 2'h3;

  typedef enum logic [1:0] {
    ADDR_BANKED = 2'h0,
    ADDR_ACCESS = 2'h1,
    ADDR_INDEXED = 2'h2
  } addr_mode_t;

  typedef struct packed {
    logic [11:0] addr;
    addr_mode_t mode;
  } file_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } fetch_t;
endpackage

// ---- sim/bit_test_skip_execution_test.sv ----
// testbench: bit-test-skip execution, set and clear forms and file addressing
`timescale 1ns/1ps
module bit_test_skip_execution_test;
  import bit_skip_pkg::*;
  logic clk_sys;
  logic rst;
  fetch_t fetch;
  logic [3:0] bank_selector;
  logic ext_set_en;
  logic [11:0] index_base;
  logic [7:0] file_rdata;
  logic [11:0] file_addr_reg;
  logic file_rd_reg;
  addr_mode_t addr_mode_reg;
  logic [1:0] phase_reg;
  logic skip_reg;
  logic nop_reg;
  logic busy_reg;
  int n_errors = 0;
  int total_checks = 0;

  bit_test_skip_exec bit_test_skip_exec_i (
    .clk_sys(clk_sys), .rst(rst), .fetch(fetch), .bank_selector(bank_selector),
    .ext_set_en(ext_set_en), .index_base(index_base), .file_rdata(file_rdata),
    .file_addr_reg(file_addr_reg), .file_rd_reg(file_rd_reg),
    .addr_mode_reg(addr_mode_reg), .phase_reg(phase_reg), .skip_reg(skip_reg),
    .nop_reg(nop_reg), .busy_reg(busy_reg)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    if (n_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // one test instruction, then a test word as prefetch that a skip must swallow
  task automatic run(input logic [15:0] word, input logic [7:0] rdata,
                     input logic [11:0] exp_addr, input addr_mode_t exp_mode,
                     input logic exp_skip);
    @(negedge clk_sys);
    while (phase_reg !== 2'h3) @(negedge clk_sys);
    fetch = {1'b1, word};
    @(negedge clk_sys);
    check(16'(file_rd_reg), 16'h0001);
    check(16'(file_addr_reg), 16'(exp_addr));
    check(16'(addr_mode_reg), 16'(exp_mode));
    fetch = {1'b1, OPC_SKIP_WHEN_CLEAR, 3'h0, 1'b0, 8'h10};
    file_rdata = rdata;
    repeat (4) @(negedge clk_sys);
    check(16'(skip_reg), 16'(exp_skip));
    check(16'(nop_reg), 16'(exp_skip));
    check(16'(busy_reg), 16'(exp_skip));
    check(16'(file_rd_reg), 16'(!exp_skip));
    fetch = '0;
    // bit 0 set keeps the swallowed-or-decoded clear-form prefetch from skipping
    file_rdata = 8'h01;
    repeat (4) @(negedge clk_sys);
    check(16'(skip_reg), 16'h0000);
    check(16'(busy_reg), 16'h0000);
  endtask

  task automatic skip_when_set_cases;
    bank_selector = 4'h5;
    ext_set_en = 1'b0;
    run({OPC_SKIP_WHEN_SET, 3'h7, 1'b1, 8'h20}, 8'h80, 12'h520, ADDR_BANKED, 1'b1);
    run({OPC_SKIP_WHEN_SET, 3'h7, 1'b1, 8'h20}, 8'h7F, 12'h520, ADDR_BANKED, 1'b0);
  endtask

  task automatic skip_when_clear_cases;
    bank_selector = 4'hA;
    run({OPC_SKIP_WHEN_CLEAR, 3'h3, 1'b1, 8'hC4}, 8'hF7, 12'hAC4, ADDR_BANKED, 1'b1);
    run({OPC_SKIP_WHEN_CLEAR, 3'h3, 1'b1, 8'hC4}, 8'h08, 12'hAC4, ADDR_BANKED, 1'b0);
  endtask

  task automatic addressing_cases;
    bank_selector = 4'h7;
    index_base = 12'h300;
    run({OPC_SKIP_WHEN_SET, 3'h0, 1'b0, 8'h5F}, 8'h00, 12'h05F, ADDR_ACCESS, 1'b0);
    run({OPC_SKIP_WHEN_SET, 3'h0, 1'b0, 8'h60}, 8'h00, 12'hF60, ADDR_ACCESS, 1'b0);
    ext_set_en = 1'b1;
    run({OPC_SKIP_WHEN_SET, 3'h0, 1'b0, 8'h5F}, 8'h00, 12'h35F, ADDR_INDEXED, 1'b0);
    run({OPC_SKIP_WHEN_SET, 3'h0, 1'b0, 8'h60}, 8'h00, 12'hF60, ADDR_ACCESS, 1'b0);
    run({OPC_SKIP_WHEN_SET, 3'h0, 1'b1, 8'h10}, 8'h00, 12'h710, ADDR_BANKED, 1'b0);
  endtask

  // a skip swallows one prefetched word, the word arriving during the nop runs,
  // and a reset inside a nop clears every output and restarts the phase count
  task automatic skip_chain_case;
    bank_selector = 4'h2;
    ext_set_en = 1'b0;
    @(negedge clk_sys);
    while (phase_reg !== 2'h3) @(negedge clk_sys);
    fetch = {1'b1, OPC_SKIP_WHEN_SET, 3'h1, 1'b1, 8'h33};
    @(negedge clk_sys);
    check(16'({file_rd_reg, file_addr_reg}), 16'h1233);
    fetch = {1'b1, OPC_SKIP_WHEN_CLEAR, 3'h2, 1'b1, 8'h55};
    file_rdata = 8'h02;
    repeat (4) @(negedge clk_sys);
    check(16'({skip_reg, nop_reg, busy_reg, file_rd_reg}), 16'h000E);
    check(16'(file_addr_reg), 16'h0233);
    fetch = {1'b1, OPC_SKIP_WHEN_SET, 3'h0, 1'b1, 8'h44};
    file_rdata = 8'h01;
    repeat (4) @(negedge clk_sys);
    check(16'({file_rd_reg, file_addr_reg}), 16'h1244);
    check(16'({skip_reg, nop_reg, busy_reg}), 16'h0000);
    fetch = '0;
    repeat (4) @(negedge clk_sys);
    check(16'({skip_reg, nop_reg, busy_reg, file_rd_reg}), 16'h000E);
    rst = 1'b1;
    @(negedge clk_sys);
    check(16'({skip_reg, nop_reg, busy_reg, file_rd_reg, phase_reg}), 16'h0000);
    check(16'({addr_mode_reg, file_addr_reg}), 16'h0000);
    rst = 1'b0;
    repeat (2) @(negedge clk_sys);
    check(16'(phase_reg), 16'h0002);
  endtask

  initial begin
    #20000;
    n_errors++;
    conclude();
  end

  initial begin
    rst = 1'b1;
    fetch = '0;
    bank_selector = 4'h0;
    ext_set_en = 1'b0;
    index_base = 12'h000;
    file_rdata = 8'h01;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    skip_when_set_cases();
    skip_when_clear_cases();
    addressing_cases();
    skip_chain_case();
    conclude();
  end
endmodule
